/* File: verilog/iwd_defines.svh */
// Offsets, keys, field positions and reset values of the watchdog
`ifndef IWD_DEFINES_SVH
`define IWD_DEFINES_SVH

`define IWD_OFF_KEY          8'h00
`define IWD_OFF_PRESCALER    8'h04
`define IWD_OFF_RELOAD       8'h08
`define IWD_OFF_STATUS       8'h0C
`define IWD_OFF_DEBUG        8'h10

`define IWD_KEY_START        16'hCCCC
`define IWD_KEY_RELOAD       16'hAAAA
`define IWD_KEY_UNLOCK       16'h5555

`define IWD_KEY_MSB          15
`define IWD_PD_MSB           2
`define IWD_REL_MSB          11
`define IWD_STS_PVU_BIT      0
`define IWD_STS_RELOAD_UPDATE_BUSY_BIT     1
`define IWD_DBG_FREEZE_BIT   0

`define IWD_RST_PD           3'h0
`define IWD_RST_REL          12'hFFF
`define IWD_CNT_INIT         12'hFFF
`define IWD_CNT_ZERO         12'h000

`endif

/* File: verilog/iwd_pkg.sv */
// Types shared by the watchdog design
package iwd_pkg;

  typedef enum logic [1:0] {
    CNT_OFF,
    CNT_RUN,
    CNT_FIRED
  } iwd_cnt_e;

  // One pending transfer of a value into the slow oscillator domain
  typedef struct packed {
    logic busy;
    logic copied;
  } iwd_upd_s;

  typedef logic [11:0] iwd_count_t;

endpackage

/* File: verilog/iwd_top.sv */
// Independent watchdog with APB register slave
// Operation
// - Start key enables the watchdog; counter counts down from all ones.
// - Counter reaching zero while enabled asserts the reset output.
// - Reload key loads the counter with the current reload value.
// - After a reload, every round starts from the programmed reload value.
// - Hardware-watchdog option starts counting after power-on without software.
// - Prescaler and reload writes are rejected unless unlocked first.
// - Any key other than unlock restores write protection.
// - Reload key also restores write protection.
// - Update-busy flag is set while a new value is transferred.
// - Update-busy flag clears once the transfer has completed.
// - Reads during an update may be stale; valid once flag clears.
// - A started update completes by itself, even in low-power modes.
// - Counter ticks on prescaled slow clock; codes give /4 to /256.
// - Counting is driven by the independent low-speed oscillator.
// - Watchdog keeps operating in all run, sleep and standby modes.
// - In debug halt the counter freezes when the freeze bit is one.
// - With hardware-watchdog option, the start key has no effect.
// - Only the low 16 key bits carry the key; upper bits reserved.
`timescale 1ns/10ps
`include "iwd_defines.svh"

module iwd_top
  import iwd_pkg::*;
#(
  parameter int PRESC_W = 8
) (
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Low-speed oscillator, option strap, debug halt
  input  wire logic        low_speed_osc,
  input  wire logic        software_start_option,
  input  wire logic        core_halted,
  // System reset request
  output logic             watchdog_reset_out
);

  // Counter, reload and prescaler state
  iwd_cnt_e            cnt_state;
  iwd_count_t          count;
  iwd_count_t          rel_shadow;
  iwd_count_t          rel_active;
  logic [2:0]          pd_shadow;
  logic [2:0]          pd_active;
  iwd_upd_s            prescaler_update_busy;
  iwd_upd_s            reload_update_busy;
  logic                unlocked;
  logic                debug_freeze_bit;
  logic                hw_mode;
  logic                strap_done;
  logic                osc_q;
  logic [PRESC_W-1:0]  presc_cnt;
  // Bus decode and tick strobes
  logic                access;
  logic                wr;
  logic [15:0]         key_value_field;
  logic                key_wr;
  logic                slow_tick;
  logic                div_tick;
  logic                frozen;
  logic [31:0]         next_rdata;
  logic                next_err;
  logic                key_start;
  logic                key_reload;
  logic                key_unlock;
  logic                wr_psc;
  logic                wr_rel;
  logic                wr_dbg;
  logic                take_psc;
  logic                take_rel;
  logic                running;
  logic                fire_now;

  // Terminal count of the prescaler for a given code
  function automatic logic [PRESC_W-1:0] div_limit(input logic [2:0] code);
    logic [PRESC_W-1:0] lim;
    lim = '0;
    unique case (code)
      3'h0:    lim = PRESC_W'(3);
      3'h1:    lim = PRESC_W'(7);
      3'h2:    lim = PRESC_W'(15);
      3'h3:    lim = PRESC_W'(31);
      3'h4:    lim = PRESC_W'(63);
      3'h5:    lim = PRESC_W'(127);
      default: lim = PRESC_W'(255);
    endcase
    return lim;
  endfunction

  // Byte address match; every register is one aligned word
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // Shared transfer sequencing: set on an accepted write, copy on the
  // next slow tick, clear on the tick after, so busy never drops
  // before the new value is the one in use
  function automatic iwd_upd_s upd_next(input iwd_upd_s u,
                                        input logic     start,
                                        input logic     tick);
    iwd_upd_s n;
    n = u;
    if (start) begin
      n = '{busy: 1'b1, copied: 1'b0};
    end else if (tick && u.busy) begin
      if (!u.copied) begin
        n.copied = 1'b1;
      end else begin
        n = '0;
      end
    end
    return n;
  endfunction

  // Writes and reads complete at the edge where pready is sampled high
  assign access          = psel & penable & pready;
  assign wr              = access & pwrite;
  assign key_value_field = pwdata[`IWD_KEY_MSB:0];
  assign key_wr          = wr & hit(paddr, `IWD_OFF_KEY);
  assign slow_tick       = low_speed_osc & ~osc_q;
  assign div_tick        = slow_tick & (presc_cnt == div_limit(pd_active));
  assign frozen          = core_halted & debug_freeze_bit;

  // Key decode looks only at the low half; upper bits are reserved
  assign key_start  = key_wr & (key_value_field == `IWD_KEY_START);
  assign key_reload = key_wr & (key_value_field == `IWD_KEY_RELOAD);
  assign key_unlock = key_wr & (key_value_field == `IWD_KEY_UNLOCK);

  // Per-register write strobes, qualified by the completing bus edge
  assign wr_psc = wr & hit(paddr, `IWD_OFF_PRESCALER);
  assign wr_rel = wr & hit(paddr, `IWD_OFF_RELOAD);
  assign wr_dbg = wr & hit(paddr, `IWD_OFF_DEBUG);

  // A write while locked or still busy is dropped, never queued
  assign take_psc = wr_psc & unlocked & ~prescaler_update_busy.busy;
  assign take_rel = wr_rel & unlocked & ~reload_update_busy.busy;

  // Expiry is seen in the cycle the counter stands at zero; a reload
  // key in that very cycle still wins and saves the device
  assign running  = (cnt_state == CNT_RUN);
  assign fire_now = running & (count == `IWD_CNT_ZERO) & ~key_reload;

  // Read mux; the key register is write-only and reads zero
  // Active values are read, so a read during an update shows the old one until the copy tick
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    if (hit(paddr, `IWD_OFF_KEY)) begin
      next_rdata = 32'h0000_0000;
    end else if (hit(paddr, `IWD_OFF_PRESCALER)) begin
      next_rdata[`IWD_PD_MSB:0] = pd_active;
    end else if (hit(paddr, `IWD_OFF_RELOAD)) begin
      next_rdata[`IWD_REL_MSB:0] = rel_active;
    end else if (hit(paddr, `IWD_OFF_STATUS)) begin
      next_rdata[`IWD_STS_PVU_BIT]  = prescaler_update_busy.busy;
      next_rdata[`IWD_STS_RELOAD_UPDATE_BUSY_BIT] = reload_update_busy.busy;
    end else if (hit(paddr, `IWD_OFF_DEBUG)) begin
      next_rdata[`IWD_DBG_FREEZE_BIT] = debug_freeze_bit;
    end else begin
      next_err = 1'b1;
    end
  end

  // One wait state keeps every bus output straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
      pslverr <= next_err;
    end else begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // Write protection of prescaler and reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlocked <= 1'b0;
    end else if (key_wr) begin
      unlocked <= key_unlock;
    end
  end

  // Debug control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_freeze_bit <= 1'b0;
    end else if (wr_dbg) begin
      debug_freeze_bit <= pwdata[`IWD_DBG_FREEZE_BIT];
    end
  end

  // Option strap caught once, the first edge after reset release
  // Later strap changes are ignored until the next reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hw_mode    <= 1'b0;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      hw_mode    <= ~software_start_option;
      strap_done <= 1'b1;
    end
  end

  // Oscillator edge detect
  // Input is taken as synchronous to pclk, so one flop is enough
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_q <= 1'b0;
    end else begin
      osc_q <= low_speed_osc;
    end
  end

  // Prescaler transfer flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescaler_update_busy <= '0;
    end else begin
      prescaler_update_busy <= upd_next(prescaler_update_busy, take_psc, slow_tick);
    end
  end

  // Prescaler value: shadow on the bus write, active on the copy tick.
  // Nothing here depends on power mode, so the copy always finishes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_shadow <= `IWD_RST_PD;
      pd_active <= `IWD_RST_PD;
    end else if (take_psc) begin
      pd_shadow <= pwdata[`IWD_PD_MSB:0];
    end else if (slow_tick && prescaler_update_busy.busy && !prescaler_update_busy.copied) begin
      pd_active <= pd_shadow;
    end
  end

  // Reload transfer flags, same scheme
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_update_busy <= '0;
    end else begin
      reload_update_busy <= upd_next(reload_update_busy, take_rel, slow_tick);
    end
  end

  // Reload value; a new value does not itself reload the counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_shadow <= `IWD_RST_REL;
      rel_active <= `IWD_RST_REL;
    end else if (take_rel) begin
      rel_shadow <= pwdata[`IWD_REL_MSB:0];
    end else if (slow_tick && reload_update_busy.busy && !reload_update_busy.copied) begin
      rel_active <= rel_shadow;
    end
  end

  // Prescaler counter on slow oscillator edges
  // Phase is kept while frozen so a halt does not shorten a period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_cnt <= '0;
    end else if (!running || frozen) begin
      presc_cnt <= presc_cnt;
    end else if (div_tick) begin
      presc_cnt <= '0;
    end else if (slow_tick) begin
      presc_cnt <= presc_cnt + PRESC_W'(1);
    end
  end

  // Run state; no power-mode input gates it, so it runs in every mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_state <= CNT_OFF;
    end else begin
      unique case (cnt_state)
        CNT_OFF: begin
          if (hw_mode) begin
            cnt_state <= CNT_RUN;
          end else if (key_start) begin
            cnt_state <= CNT_RUN;
          end
        end
        CNT_RUN: begin
          // Start key while running changes nothing, hardware mode too
          if (fire_now) begin
            cnt_state <= CNT_FIRED;
          end
        end
        CNT_FIRED: begin
          // Only a system reset leaves this state
          cnt_state <= CNT_FIRED;
        end
      endcase
    end
  end

  // Down-counter; a reload key loads it even before the start key
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= `IWD_CNT_INIT;
    end else if (cnt_state == CNT_FIRED) begin
      count <= `IWD_CNT_ZERO;
    end else if (key_reload) begin
      count <= rel_active;
    end else if (running && count != `IWD_CNT_ZERO &&
                 div_tick && !frozen) begin
      count <= count - 12'h001;
    end
  end

  // Reset request held until the system reset clears the block
  // Sticky level, so slow reset logic cannot miss a short pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_reset_out <= 1'b0;
    end else if (fire_now) begin
      watchdog_reset_out <= 1'b1;
    end
  end

endmodule

/* File: tb/iwd_properties.sv */
// Bus and reset-output checks bound onto the watchdog top
`timescale 1ns/10ps
module iwd_properties (
  // Clock, reset and bus
  input wire logic        pclk, presetn, psel, penable, pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic        pready, pslverr,
  // Watchdog pins
  input wire logic        low_speed_osc, software_start_option,
  input wire logic        core_halted, watchdog_reset_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd_done = pready && !pwrite;
  a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_data_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer cycle");
  a_err_map: assert property (pready |-> pslverr ==
      !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}))
    else $error("error response does not match address map");
  a_err_alone: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_key_zero: assert property (rd_done && paddr == 8'h00 |-> !prdata)
    else $error("key register read not zero");
  a_rsv_psc: assert property (rd_done && paddr == 8'h04 |-> !prdata[31:3])
    else $error("prescaler reserved bits set");
  a_rsv_rel: assert property (rd_done && paddr == 8'h08 |-> !prdata[31:12])
    else $error("reload reserved bits set");
  a_rsv_sts: assert property (rd_done && paddr == 8'h0C |-> !prdata[31:2])
    else $error("status reserved bits set");
  a_reset_hold: assert property ($rose(watchdog_reset_out) |=> watchdog_reset_out[*8])
    else $error("reset output dropped before system reset");
  c_write: cover property (pready && pwrite);
  c_read_rel: cover property (rd_done && paddr == 8'h08);
  c_fire: cover property ($rose(watchdog_reset_out));
endmodule
bind iwd_top iwd_properties iwd_properties_inst (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .low_speed_osc, .software_start_option, .core_halted, .watchdog_reset_out);

/* File: tb/iwd_top_tb.sv */
// Self-checking bench for the watchdog
`timescale 1ns/10ps
`include "iwd_defines.svh"
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin miscompares++; \
  $display("wrong value at %0t: %s", $time, m); end end
module iwd_top_tb;
  // Slow oscillator far faster than real, to keep runs short
  localparam int OSC = 8;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, rd;
  logic low_speed_osc = 0, software_start_option = 1, core_halted = 0, er;
  wire logic pready, pslverr, watchdog_reset_out;
  wire logic [31:0] prdata;
  int checks = 0, miscompares = 0, oc = 0;
  iwd_top iwd_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .low_speed_osc,
    .software_start_option, .core_halted, .watchdog_reset_out);
  initial forever #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    oc <= (oc == OSC - 1) ? 0 : oc + 1;
    low_speed_osc <= (oc < OSC / 2);
  end
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    `CHK(n < 20, 1'b1, "no ready")
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    `CHK(rd, e, "read back")
  endtask
  task automatic tk(input int t);
    repeat (t * OSC) @(posedge pclk);
  endtask
  task automatic rst(input logic hw);
    presetn <= 0;
    core_halted <= 0;
    software_start_option <= !hw;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
  endtask
  task automatic idle_wait();
    int n;
    n = 0;
    do begin
      apb(0, `IWD_OFF_STATUS, 0);
      n++;
    end while (rd[1:0] !== 2'b00 && n < 50);
    `CHK(rd[1:0], 2'b00, "busy stuck")
  endtask
  task automatic prot(input logic [31:0] k1, k2, input logic [11:0] e);
    apb(1, `IWD_OFF_KEY, k1);
    apb(1, `IWD_OFF_KEY, k2);
    apb(1, `IWD_OFF_RELOAD, 5);
    rdc(`IWD_OFF_STATUS, (e == 12'h005) ? 2'b10 : 2'b00);
    idle_wait();
    rdc(`IWD_OFF_RELOAD, e);
  endtask
  task automatic lock_test();
    rst(0);
    rdc(`IWD_OFF_KEY, 0);
    rdc(`IWD_OFF_PRESCALER, `IWD_RST_PD);
    rdc(`IWD_OFF_RELOAD, `IWD_RST_REL);
    rdc(`IWD_OFF_STATUS, 0);
    apb(0, 8'h14, 0);
    `CHK(er, 1'b1, "unmapped access accepted")
    prot(16'h1234, 16'h1234, `IWD_RST_REL);
    prot(`IWD_KEY_UNLOCK, 16'h1234, `IWD_RST_REL);
    prot(`IWD_KEY_UNLOCK, `IWD_KEY_RELOAD, `IWD_RST_REL);
    prot(`IWD_KEY_UNLOCK, 32'hFFFF_5555, 12'h005);
    $display("lock test done");
  endtask
  // Reload of 3 keeps fire time apart from neighbouring divider codes
  task automatic fire(input logic [2:0] c, input logic hw, frz);
    int div;
    div = (c > 5) ? 256 : 4 << c;
    rst(hw);
    apb(1, `IWD_OFF_KEY, `IWD_KEY_UNLOCK);
    apb(1, `IWD_OFF_PRESCALER, c);
    apb(1, `IWD_OFF_RELOAD, 3);
    apb(1, `IWD_OFF_DEBUG, frz);
    idle_wait();
    core_halted <= 1;
    apb(1, `IWD_OFF_KEY, `IWD_KEY_RELOAD);
    apb(1, `IWD_OFF_KEY, `IWD_KEY_START);
    if (frz) begin
      tk(6 * div);
      `CHK(watchdog_reset_out, 1'b0, "counted while frozen")
      core_halted <= 0;
    end
    tk(2 * div - 1);
    `CHK(watchdog_reset_out, 1'b0, "early reset")
    tk(div + 3);
    `CHK(watchdog_reset_out, 1'b1, "missing reset")
    $display("fire test code %0d done", c);
  endtask
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #2_000_000;
    miscompares++;
    wrap_up();
  end
  initial begin
    lock_test();
    for (int c = 0; c < 8; c++) fire(c, 0, 0);
    fire(3'h0, 1, 0);
    fire(3'h1, 0, 1);
    wrap_up();
  end
endmodule
